// file: verilog/nvs_cfg.svh
/*
 * Constants of the settings save/restore controller: register offsets, bit
 * positions, list operation codes, default list contents and reset values.
 * Assumes it is included by bare name from each design file that needs it.
 */
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH

// ----------------------------------------------------------------------------
// Register offsets (12-bit serial port address space)
// ----------------------------------------------------------------------------
`define NVS_REG_STATUS 12'hB00
`define NVS_REG_ERROR 12'hB01
`define NVS_REG_RELOAD 12'hB02
`define NVS_REG_SAVE 12'hB03
`define NVS_LIST_PAGE 4'hA

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define NVS_BIT_BUSY 0
`define NVS_BIT_ERROR 0
`define NVS_BIT_UNLOCK 0
`define NVS_BIT_RELOAD 1
`define NVS_BIT_SAVE 0
`define NVS_BIT_OPCODE 7

// ----------------------------------------------------------------------------
// Transfer list operation codes and defaults
// ----------------------------------------------------------------------------
`define NVS_OP_APPLY 8'h80
`define NVS_OP_END 8'hFF
`define NVS_DEF_CMD 8'h7F
`define NVS_DEF_ADDR_HI 8'h00
`define NVS_DEF_ADDR_LO 8'h00
`define NVS_ERASED 8'hFF
`define NVS_UNLOCK_RST 1'b0

`endif

// file: verilog/nvs_pkg.sv
/*
 * Types shared by the settings save/restore controller and its buffer register bank.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package nvs_pkg;

	// Gray codes along idle -> command -> address -> data -> checksum
	typedef enum logic [2:0] {
		NVS_IDLE = 3'h0,
		NVS_CMD = 3'h1,
		NVS_AHI = 3'h3,
		NVS_ALO = 3'h2,
		NVS_DATA = 3'h6,
		NVS_CSUM = 3'h7
	} nvs_state_t;

	// Access to the buffer register bank
	typedef struct packed {
		logic we;
		logic [15:0] addr;
		logic [7:0] data;
	} nvs_buf_req_t;

endpackage

// file: verilog/nvs_nvm_array.sv
/*
 * Nonvolatile byte store model: combinational read, clocked write gated by
 * the write unlock. Assumes the controller presents one write per cycle.
 */
`timescale 1ns/1ns
`include "nvs_cfg.svh"

module nvs_nvm_array #(
	parameter int AW = 10
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic we,
	input wire logic unlock,
	input wire logic [AW-1:0] addr,
	input wire logic [7:0] wdata,
	output logic [7:0] rdata
);
	logic [7:0] mem_q [0:(1<<AW)-1];
	logic [7:0] mem_d [0:(1<<AW)-1];

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	always_comb begin
		mem_d = mem_q;
		if (we && unlock) begin
			mem_d[addr] = wdata;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < (1<<AW); i++) begin
				mem_q[i] <= `NVS_ERASED;
			end
		end else begin
			mem_q <= mem_d;
		end
	end

	assign rdata = mem_q[addr];
endmodule

// file: verilog/nvs_ctrl.sv
/*
 * Settings save/restore controller: status, error, reload/unlock and save
 * registers, the transfer list at page 0xA, and the sequencer that copies
 * buffer registers to and from the nonvolatile store.
 * Assumes the serial port front end turns frames into single-cycle register
 * strobes, and that the buffer bank answers a read in the same cycle.
 */
// Overview of operation
// - Status bit reads 1 while transfer runs
// - Status pin shows busy when selected
// - Error bit flags bad data on load
// - Reload bit with pin low reloads, self-clears
// - Unlock bit default 0 blocks memory writes
// - Save bit starts buffer-to-memory copy
// - Save bit stays set until copy ends
// - Bit7 clear: count-1, then address MSB first
// - Bit7 set: opcode; end-of-data stops walk
// - Apply opcode copies buffer to active registers on load only
`timescale 1ns/1ns
`include "nvs_cfg.svh"

module nvs_ctrl
	import nvs_pkg::*;
#(
	parameter int NVM_AW = 10
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic nvm_pin,
	input wire logic status_sel,
	output logic status_pin,
	output nvs_buf_req_t buf_req,
	input wire logic [7:0] buf_rdata,
	output logic apply_pulse,
	output logic soft_reset_pulse
);
	nvs_state_t st_q, st_d;
	logic save_q, save_d;
	logic [7:0] lp_q, lp_d;
	logic [NVM_AW-1:0] np_q, np_d;
	logic [6:0] cnt_q, cnt_d;
	logic [7:0] sum_q, sum_d;
	logic err_q, err_d;
	logic trig_q, trig_d;
	logic unlock_q, unlock_d;
	logic reload_q, reload_d;
	logic apply_q, apply_d;
	logic srst_q, srst_d;
	logic stpin_q, stpin_d;
	logic [7:0] rdata_q, rdata_d;
	nvs_buf_req_t buf_q, buf_d;
	logic [7:0] list_q [0:255];
	logic [7:0] list_d [0:255];
	logic [7:0] nvm_rdata;
	logic [7:0] src;
	logic nvm_we;
	logic [7:0] nvm_wdata;
	logic busy;
	logic step;

	// ------------------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------------------
	nvs_nvm_array #(
		.AW(NVM_AW)
	) u_store (
		.clk(clk),
		.arst_n(arst_n),
		.we(nvm_we),
		.unlock(unlock_q),
		.addr(np_q),
		.wdata(nvm_wdata),
		.rdata(nvm_rdata)
	);

	assign busy = (st_q != NVS_IDLE);
	// Saving reads the list, then the buffer bank; loading reads only the store
	assign src = save_q ? ((st_q == NVS_DATA) ? buf_rdata : list_q[lp_q]) : nvm_rdata;
	assign nvm_we = save_q && busy;
	assign nvm_wdata = (st_q == NVS_CSUM) ? sum_q : src;

	// ------------------------------------------------------------------------
	// Register file and sequencer, next values
	// ------------------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		save_d = save_q;
		lp_d = lp_q;
		np_d = np_q;
		cnt_d = cnt_q;
		sum_d = sum_q;
		err_d = err_q;
		trig_d = trig_q;
		unlock_d = unlock_q;
		reload_d = reload_q;
		apply_d = 1'b0;
		srst_d = 1'b0;
		rdata_d = rdata_q;
		list_d = list_q;
		buf_d = buf_q;
		buf_d.we = 1'b0;
		step = 1'b0;

		// Host writes; a trigger while busy is ignored so a walk is never restarted
		if (reg_wr) begin
			if (reg_addr[11:8] == `NVS_LIST_PAGE) begin
				list_d[reg_addr[7:0]] = reg_wdata;
			end else if (reg_addr == `NVS_REG_RELOAD) begin
				unlock_d = reg_wdata[`NVS_BIT_UNLOCK];
				if (reg_wdata[`NVS_BIT_RELOAD] && !nvm_pin && !busy) begin
					reload_d = 1'b1;
				end
			end else if (reg_addr == `NVS_REG_SAVE) begin
				if (reg_wdata[`NVS_BIT_SAVE] && !busy) begin
					trig_d = 1'b1;
				end
			end
		end

		if (reg_rd) begin
			if (reg_addr[11:8] == `NVS_LIST_PAGE) begin
				rdata_d = list_q[reg_addr[7:0]];
			end else if (reg_addr == `NVS_REG_STATUS) begin
				rdata_d = {7'h00, busy};
			end else if (reg_addr == `NVS_REG_ERROR) begin
				rdata_d = {7'h00, err_q};
			end else if (reg_addr == `NVS_REG_RELOAD) begin
				rdata_d = {6'h00, reload_q, unlock_q};
			end else if (reg_addr == `NVS_REG_SAVE) begin
				rdata_d = {7'h00, trig_q};
			end else begin
				rdata_d = 8'h00;
			end
		end

		unique case (st_q)
			NVS_IDLE: begin
				lp_d = 8'h00;
				np_d = '0;
				sum_d = 8'h00;
				if (trig_q) begin
					save_d = 1'b1;
					err_d = 1'b0;
					st_d = NVS_CMD;
				end else if (reload_q) begin
					save_d = 1'b0;
					err_d = 1'b0;
					reload_d = 1'b0;
					srst_d = 1'b1;
					st_d = NVS_CMD;
				end
			end
			NVS_CMD: begin
				step = 1'b1;
				if (!src[`NVS_BIT_OPCODE]) begin
					cnt_d = src[6:0];
					st_d = NVS_AHI;
				end else if (src == `NVS_OP_APPLY) begin
					apply_d = !save_q;
				end else begin
					st_d = NVS_CSUM;
				end
			end
			NVS_AHI: begin
				step = 1'b1;
				buf_d.addr[15:8] = src;
				st_d = NVS_ALO;
			end
			NVS_ALO: begin
				step = 1'b1;
				buf_d.addr[7:0] = src;
				st_d = NVS_DATA;
			end
			NVS_DATA: begin
				step = 1'b1;
				if (!save_q) begin
					buf_d.we = 1'b1;
					buf_d.data = src;
					buf_d.addr = buf_q.addr;
				end
				cnt_d = cnt_q - 7'h01;
				if (cnt_q == 7'h00) begin
					st_d = NVS_CMD;
				end
			end
			NVS_CSUM: begin
				if (!save_q && (nvm_rdata != sum_q)) begin
					err_d = 1'b1;
				end
				trig_d = 1'b0;
				st_d = NVS_IDLE;
			end
			default: begin
				st_d = NVS_IDLE;
			end
		endcase

		// One byte moves per step; running off the end of the store is an error
		if (step) begin
			sum_d = sum_q + src;
			np_d = np_q + 1'b1;
			if (save_q && (st_q != NVS_DATA)) begin
				lp_d = lp_q + 8'h01;
			end
			if (&np_q) begin
				err_d = 1'b1;
				trig_d = 1'b0;
				st_d = NVS_IDLE;
			end
		end

		// Load writes go to the current address; the pointer moves on after
		if (st_q == NVS_DATA && save_q) begin
			buf_d.addr = buf_q.addr + 16'h0001;
		end else if (st_q == NVS_DATA && buf_q.we) begin
			buf_d.addr = buf_q.addr + 16'h0001;
		end
		stpin_d = status_sel && (st_d != NVS_IDLE);
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= NVS_IDLE;
			save_q <= 1'b0;
			lp_q <= 8'h00;
			np_q <= '0;
			cnt_q <= 7'h00;
			sum_q <= 8'h00;
			err_q <= 1'b0;
			trig_q <= 1'b0;
			unlock_q <= `NVS_UNLOCK_RST;
			reload_q <= 1'b0;
			apply_q <= 1'b0;
			srst_q <= 1'b0;
			stpin_q <= 1'b0;
			rdata_q <= 8'h00;
			buf_q <= '0;
			for (int i = 0; i < 256; i++) begin
				list_q[i] <= `NVS_OP_END;
			end
			list_q[0] <= `NVS_DEF_CMD;
			list_q[1] <= `NVS_DEF_ADDR_HI;
			list_q[2] <= `NVS_DEF_ADDR_LO;
			list_q[3] <= `NVS_OP_APPLY;
		end else begin
			st_q <= st_d;
			save_q <= save_d;
			lp_q <= lp_d;
			np_q <= np_d;
			cnt_q <= cnt_d;
			sum_q <= sum_d;
			err_q <= err_d;
			trig_q <= trig_d;
			unlock_q <= unlock_d;
			reload_q <= reload_d;
			apply_q <= apply_d;
			srst_q <= srst_d;
			stpin_q <= stpin_d;
			rdata_q <= rdata_d;
			buf_q <= buf_d;
			list_q <= list_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign status_pin = stpin_q;
	assign buf_req = buf_q;
	assign apply_pulse = apply_q;
	assign soft_reset_pulse = srst_q;
endmodule

// file: verification/nvs_ctrl_monitor.sv
/*
 * Port checker for nvs_ctrl, bound at the foot of this file.
 * Assumes status_sel only changes while no transfer runs.
 */
`timescale 1ns/1ns
module nvs_ctrl_monitor
	import nvs_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [11:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic nvm_pin,
	input wire logic status_sel,
	input wire logic status_pin,
	input wire nvs_buf_req_t buf_req,
	input wire logic apply_pulse,
	input wire logic soft_reset_pulse
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	sequence idle_sel;
		!status_pin && status_sel;
	endsequence
	sequence reload_wr;
		reg_wr && reg_addr == 12'hB02 && reg_wdata[1];
	endsequence
	save_start_a:
		assert property (reg_wr && reg_addr == 12'hB03 && reg_wdata[0] ##0 idle_sel
			|-> ##2 status_pin) else $error("save did not start");
	reload_go_a:
		assert property (reload_wr ##0 !nvm_pin ##0 idle_sel |-> ##2 soft_reset_pulse)
			else $error("reload did not start");
	reload_deny_a:
		assert property (reload_wr ##0 nvm_pin |=> !soft_reset_pulse [*3])
			else $error("reload taken with pin high");
	apply_one_a:
		assert property (apply_pulse |=> !apply_pulse) else $error("apply pulse too long");
	apply_busy_a:
		assert property (apply_pulse && status_sel |-> status_pin)
			else $error("apply outside a transfer");
	bus_busy_a:
		assert property (buf_req.we && status_sel |-> status_pin)
			else $error("buffer write outside a transfer");
	pin_sel_a:
		assert property (!$past(status_sel) |-> !status_pin) else $error("pin driven unselected");
	status_ro_a:
		assert property (reg_rd && reg_addr == 12'hB00 |=> reg_rdata[7:1] == 7'h00)
			else $error("status upper bits set");
endmodule

bind nvs_ctrl nvs_ctrl_monitor u_nvs_ctrl_monitor (.clk(clk), .arst_n(arst_n),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .nvm_pin(nvm_pin), .status_sel(status_sel),
	.status_pin(status_pin), .buf_req(buf_req), .apply_pulse(apply_pulse),
	.soft_reset_pulse(soft_reset_pulse));

// file: verification/nvs_buf_model.sv
/*
 * Buffer register bank model: combinational read, counts and judges writes.
 * Assumes one request per cycle from nvs_ctrl.
 */
`timescale 1ns/1ns
module nvs_buf_model
	import nvs_pkg::*;
(
	input wire logic clk,
	input wire nvs_buf_req_t req,
	output logic [7:0] rdata,
	output int n_wr,
	output int n_bad
);
	int wr_cnt = 0;
	int bad_cnt = 0;
	// Content tied to address, so a replayed image is judged byte by byte
	assign rdata = req.addr[7:0] ^ 8'h5A;
	assign n_wr = wr_cnt;
	assign n_bad = bad_cnt;
	// Sampled mid-cycle, away from the edge that launches each request
	always @(negedge clk) begin
		if (req.we === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			if (req.data !== rdata) bad_cnt <= bad_cnt + 1;
		end
	end
endmodule

// file: verification/nvs_ctrl_test.sv
/*
 * Bench for nvs_ctrl with the buffer bank model.
 * Assumes the checker is bound by its own file.
 */
`timescale 1ns/1ns
module nvs_ctrl_test;
	import nvs_pkg::*;
	logic clk, arst_n, reg_wr, reg_rd, nvm_pin, status_sel;
	logic status_pin, apply_pulse, soft_reset_pulse;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, buf_rdata, v;
	nvs_buf_req_t buf_req;
	int n_errors = 0, checks_done = 0, cycles = 0, n_apply = 0, n_srst = 0, n_pin = 0;
	int n_wr, n_bad, w0, a0, s0, p0;

	nvs_ctrl #(.NVM_AW(10)) u_nvs_ctrl (.clk(clk), .arst_n(arst_n), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .nvm_pin(nvm_pin), .status_sel(status_sel),
		.status_pin(status_pin), .buf_req(buf_req), .buf_rdata(buf_rdata),
		.apply_pulse(apply_pulse), .soft_reset_pulse(soft_reset_pulse));
	nvs_buf_model u_nvs_buf_model (.clk(clk), .req(buf_req), .rdata(buf_rdata),
		.n_wr(n_wr), .n_bad(n_bad));

	// ----
	// Register port tasks
	// ----
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk) #1 reg_wr = 1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk) #1 reg_wr = 0;
	endtask
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk) #1 reg_rd = 1;
		reg_addr = a;
		@(posedge clk) #1 reg_rd = 0;
		d = reg_rdata;
	endtask
	// Polls until idle, then keeps the host gap before any further transfer
	task automatic wait_idle();
		logic [7:0] s;
		s = 8'h01;
		for (int i = 0; i < 2000 && s[0] !== 1'b0; i++) rd(12'hB00, s);
		chk("busy", 8'h00, s);
		repeat (2500) @(posedge clk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// ----
	// Scenarios
	// ----
	task automatic t_locked();
		rd(12'hB02, v);
		chk("unlock", 8'h00, v);
		p0 = n_pin;
		wr(12'hB03, 8'h01);
		rd(12'hB03, v);
		chk("save bit", 8'h01, v);
		rd(12'hB00, v);
		chk("status", 8'h01, v);
		wait_idle();
		rd(12'hB03, v);
		chk("save clear", 8'h00, v);
		chk("pin cycles", 8'h86, 8'(n_pin - p0));
		w0 = n_wr;
		s0 = n_srst;
		wr(12'hB02, 8'h02);
		wait_idle();
		chk("locked image", 8'h00, 8'(n_wr - w0));
		chk("soft reset", 8'h01, 8'(n_srst - s0));
		rd(12'hB02, v);
		chk("reload clear", 8'h00, v);
		$display("locked test done");
	endtask
	task automatic t_unlocked();
		wr(12'hB02, 8'h01);
		wr(12'hB03, 8'h01);
		wait_idle();
		w0 = n_wr;
		a0 = n_apply;
		wr(12'hB02, 8'h03);
		wait_idle();
		chk("load bytes", 8'h80, 8'(n_wr - w0));
		chk("bad bytes", 8'h00, 8'(n_bad));
		chk("apply", 8'h01, 8'(n_apply - a0));
		rd(12'hB01, v);
		chk("error", 8'h00, v);
		$display("unlocked test done");
	endtask
	task automatic t_refused();
		status_sel = 0;
		nvm_pin = 1;
		s0 = n_srst;
		wr(12'hB00, 8'hFF);
		wr(12'hB02, 8'h02);
		rd(12'hB00, v);
		chk("ro status", 8'h00, v);
		chk("no reload", 8'h00, 8'(n_srst - s0));
		nvm_pin = 0;
		p0 = n_pin;
		wr(12'hB02, 8'h02);
		wait_idle();
		chk("pin unselected", 8'h00, 8'(n_pin - p0));
		chk("reload", 8'h01, 8'(n_srst - s0));
		status_sel = 1;
		$display("refused test done");
	endtask
	task automatic t_overflow();
		wr(12'hB02, 8'h01);
		for (int i = 0; i < 9; i++) begin
			wr(12'hA00 + 12'(3 * i), 8'h7F);
			wr(12'hA01 + 12'(3 * i), 8'h00);
			wr(12'hA02 + 12'(3 * i), 8'h00);
		end
		wr(12'hA1B, 8'hFF);
		wr(12'hB03, 8'h01);
		wait_idle();
		rd(12'hB01, v);
		chk("overflow error", 8'h01, v);
		$display("overflow test done");
	endtask

	initial begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	// Outputs are counted mid-cycle, where they have settled
	always @(negedge clk) begin
		cycles++;
		if (apply_pulse === 1'b1) n_apply++;
		if (soft_reset_pulse === 1'b1) n_srst++;
		if (status_pin === 1'b1) n_pin++;
		if (cycles == 60000) begin
			n_errors++;
			complete_run();
		end
	end
	initial begin
		{arst_n, reg_wr, reg_rd, nvm_pin} = 4'h0;
		status_sel = 1;
		reg_addr = 12'h000;
		reg_wdata = 8'h00;
		repeat (8) @(posedge clk);
		#1 arst_n = 1;
		t_locked();
		t_unlocked();
		t_refused();
		t_overflow();
		complete_run();
	end
endmodule
